// >>> dpp_programmer.sv
// Data EEPROM page programmer: page buffer, address pair, command and
// status register, security checks and the stall of the processor.
// Assumes one AHB-Lite master, a 10 MHz clock and an array port that
// accepts one byte write or one page erase per cycle.
`timescale 1ns/1ps

// Behaviour
// - Program or erase-program command starts a cycle and stalls the processor.
// - Interrupt servicing is held off while a cycle runs.
// - Buffer-clear command clears all buffer bytes and their update flags.
// - Low address bits 5:0 index the buffer; bits 7:6 alone give the page.
// - Data write stores the byte then increments low address bits 5:0.
// - Erase-program is code 68H, program-only is code 48H.
// - Status reads and command writes share one register, reset zero.
// - Fault bit 0 on reset abort, protected access or high-voltage error.
// - Security violation bit 1 set on operations against a secured page.
// - Program violates on code bit 0 or page security bit 1.
// - Global, page erase and checksum violations follow their own bits.
// - Protect bit 4 refuses array access; protect sets, unprotect clears.
// - Write enable bit 6 shows array writes permitted.
// - Busy bit 7 set while an operation runs.
module dpp_programmer
    import dpp_pkg::*;
#(
    parameter int PROGRAM_ONLY_CMD_CYCLES = DPP_PROGRAM_ONLY_CMD_CYCLES
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire logic                  clk_en,
    input  wire dpp_pkg::dpp_ahb_req_t ahb_req,
    output logic                       ahb_hreadyout,
    output logic                       ahb_hresp,
    output logic [31:0]                ahb_hrdata,
    input  wire logic                  hv_error_pin,
    input  wire logic                  abort_strap,
    output logic                       cpu_stall,
    output logic                       irq_hold,
    output dpp_pkg::dpp_array_t        array_port
);
    import dpp_pkg::*;

    localparam int CW = $clog2(PROGRAM_ONLY_CMD_CYCLES + 1);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        dpp_state_t      fsm;
        logic [CW-1:0]   count;
        logic [5:0]      wr_idx;
        logic            erase_first;
        logic            data_access_protect;
        logic            secv;
        logic            fault;
        logic            busy;
        logic            mode_icp;
        logic            mode_we;
        logic [7:0]      addr_low;
        logic [7:0]      addr_high;
        logic [27:0]     security;
        logic [63:0]     upd;
        logic [63:0][7:0] buffer;
        logic            dp_valid;
        logic            dp_write;
        logic [7:0]      dp_addr;
        logic [1:0]      hv_sync;
        logic [1:0]      abort_sync;
        logic            scan_done;
        logic            hready;
        logic [31:0]     hrdata;
        logic            stall;
        dpp_array_t      arr;
    } dpp_regs_t;

    dpp_regs_t r;
    dpp_regs_t next_r;

    // Status byte as seen on a read; reserved positions stay zero
    function automatic logic [7:0] status_byte(input dpp_regs_t s);
        logic [7:0] v;
        v = 8'h00;
        v[DPP_BIT_FAULT] = s.fault;
        v[DPP_BIT_SECV]  = s.secv;
        v[DPP_BIT_DAP]   = s.data_access_protect;
        v[DPP_BIT_WE]    = s.mode_we & ~s.data_access_protect;
        v[DPP_BIT_BUSY]  = s.busy;
        return v;
    endfunction

    // Page security field for one page: three bits 0..2 per page
    function automatic logic [2:0] page_sec(input logic [27:0] sec,
                                            input logic [1:0]  pg);
        return sec[DPP_SEC_PAGE + 3*pg +: 3];
    endfunction

    logic       hv_err;
    logic [1:0] page_sel;
    logic       ahb_go;
    logic [2:0] sel_sec;
    logic [7:0] stat_now;
    assign hv_err   = r.hv_sync[1];
    // Four pages only, so the high address byte takes no part
    assign page_sel = r.addr_low[7:6];
    assign ahb_go   = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
    assign sel_sec  = page_sec(r.security, page_sel);
    assign stat_now = status_byte(r);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] cmd;
        logic       glob_v;
        next_r = r;
        cmd = r.dp_write ? ahb_req.hwdata[7:0] : 8'h00;
        glob_v = 1'b0;
        for (int p = 0; p < DPP_PAGES; p++) begin
            glob_v = glob_v | r.security[DPP_SEC_PAGE + 3*p];
        end
        next_r.hv_sync = {r.hv_sync[0], hv_error_pin};
        next_r.arr.wr_en = 1'b0;
        next_r.arr.erase = 1'b0;
        next_r.hready = 1'b1;
        // Address phase capture; data phase follows one cycle later
        next_r.dp_valid = ahb_go;
        next_r.dp_write = ahb_go & ahb_req.hwrite;
        next_r.dp_addr  = ahb_req.haddr[7:0];
        if (ahb_go && !ahb_req.hwrite) begin
            case (ahb_req.haddr[7:0])
                DPP_OFF_CMD_STAT:  next_r.hrdata = {24'h0, stat_now};
                DPP_OFF_ADDR_LOW:  next_r.hrdata = {24'h0, r.addr_low};
                DPP_OFF_ADDR_HIGH: next_r.hrdata = {24'h0, r.addr_high};
                DPP_OFF_SECURITY:  next_r.hrdata = {4'h0, r.security};
                DPP_OFF_MODE:      next_r.hrdata = {30'h0, r.mode_we,
                                                    r.mode_icp};
                default:           next_r.hrdata = 32'h0000_0000;
            endcase
        end
        // Abort strap comes from a pin: two flops before use
        next_r.abort_sync = {r.abort_sync[0], abort_strap};
        // Register writes in the data phase
        if (r.dp_write) begin
            case (r.dp_addr)
                DPP_OFF_ADDR_LOW:  next_r.addr_low = ahb_req.hwdata[7:0];
                DPP_OFF_ADDR_HIGH: next_r.addr_high = ahb_req.hwdata[7:0];
                DPP_OFF_SECURITY:  next_r.security = ahb_req.hwdata[27:0];
                DPP_OFF_MODE: begin
                    next_r.mode_icp = ahb_req.hwdata[DPP_MODE_ICP];
                    next_r.mode_we  = ahb_req.hwdata[DPP_MODE_WE];
                end
                DPP_OFF_WDATA: begin
                    if (r.data_access_protect) begin
                        next_r.fault = 1'b1;
                    end else begin
                        next_r.buffer[r.addr_low[5:0]] =
                            ahb_req.hwdata[7:0];
                        next_r.upd[r.addr_low[5:0]] = 1'b1;
                        next_r.addr_low[5:0] = r.addr_low[5:0] + 6'd1;
                    end
                end
                DPP_OFF_CMD_STAT: begin
                    case (cmd)
                        DPP_CMD_LOAD: begin
                            next_r.buffer = '0;
                            next_r.upd = '0;
                        end
                        DPP_CMD_ERASE_PRG, DPP_CMD_PROGRAM_ONLY_CMD_ONLY: begin
                            next_r.secv = 1'b0;
                            if (r.data_access_protect) begin
                                next_r.fault = 1'b1;
                            end else if (r.security[DPP_SEC_CODE] ||
                                sel_sec[1]) begin
                                next_r.secv = 1'b1;
                            end else begin
                                next_r.fault = 1'b0;
                                next_r.busy = 1'b1;
                                next_r.stall = 1'b1;
                                next_r.fsm = DPP_RUN;
                                next_r.count = '0;
                                next_r.wr_idx = 6'd0;
                                next_r.scan_done = 1'b0;
                                next_r.erase_first =
                                    (cmd == DPP_CMD_ERASE_PRG);
                            end
                        end
                        DPP_CMD_GLOB_ERS: begin
                            next_r.secv = glob_v;
                        end
                        DPP_CMD_PAGE_ERS: begin
                            next_r.secv = ~r.mode_icp &
                                sel_sec[2];
                        end
                        DPP_CMD_PAGE_CRC: begin
                            next_r.secv =
                                r.security[DPP_SEC_CRC + page_sel] &
                                ~sel_sec[1];
                        end
                        DPP_CMD_PROTECT:   next_r.data_access_protect = 1'b1;
                        DPP_CMD_UNPROTECT: next_r.data_access_protect = 1'b0;
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        // Fault sources follow the command decode, so a set wins over
        // the clear that a program start makes in the same cycle
        if (r.abort_sync[1] && !r.busy) begin
            next_r.fault = 1'b1;
        end
        if (hv_err && r.busy) begin
            next_r.fault = 1'b1;
        end
        // Program sequencer: optional erase, then flagged bytes only
        case (r.fsm)
            DPP_IDLE: ;
            DPP_RUN: begin
                next_r.count = r.count + CW'(1);
                if (r.erase_first) begin
                    next_r.arr.erase = 1'b1;
                    next_r.arr.erase_page = page_sel;
                    next_r.erase_first = 1'b0;
                end else if (r.upd[r.wr_idx] && !r.scan_done) begin
                    next_r.arr.wr_en = 1'b1;
                    next_r.arr.wr_addr = {page_sel, r.wr_idx};
                    next_r.arr.wr_data = r.buffer[r.wr_idx];
                end
                // Index parks on the last byte; scan_done keeps that byte
                // from being written again while the cycle time runs out
                if (r.wr_idx != 6'd63 || r.erase_first) begin
                    if (!r.erase_first) begin
                        next_r.wr_idx = r.wr_idx + 6'd1;
                    end
                end else begin
                    next_r.scan_done = 1'b1;
                    if (r.count >= CW'(PROGRAM_ONLY_CMD_CYCLES - 1)) begin
                        next_r.fsm = DPP_DONE;
                    end
                end
            end
            DPP_DONE: begin
                next_r.busy = 1'b0;
                next_r.stall = 1'b0;
                next_r.fsm = DPP_IDLE;
            end
            default: next_r.fsm = DPP_IDLE;
        endcase
        // Stall the bus while a cycle runs: wait states on the next access
        if (next_r.stall && ahb_go) begin
            next_r.hready = 1'b0;
            next_r.dp_valid = 1'b0;
            next_r.dp_write = 1'b0;
        end
        if (r.stall) begin
            next_r.hready = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.fsm <= DPP_IDLE;
            r.hready <= 1'b1;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign ahb_hreadyout = r.hready;
    assign ahb_hresp     = 1'b0;
    assign ahb_hrdata    = r.hrdata;
    assign cpu_stall     = r.stall;
    assign irq_hold      = r.busy;
    assign array_port    = r.arr;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_stall_busy;
        @(posedge ref_clk) disable iff (!rst_b)
        cpu_stall |-> irq_hold;
    endproperty
    a_stall_busy: assert property (p_stall_busy)
        else $error("stall without interrupt hold");

    property p_start;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && r.dp_write && r.dp_addr == DPP_OFF_CMD_STAT &&
         ahb_req.hwdata[7:0] == DPP_CMD_PROGRAM_ONLY_CMD_ONLY && !r.data_access_protect &&
         !r.security[DPP_SEC_CODE] && !sel_sec[1])
        |=> cpu_stall;
    endproperty
    a_start: assert property (p_start)
        else $error("program command did not stall");

    property p_resv;
        @(posedge ref_clk) disable iff (!rst_b)
        stat_now[5] == 1'b0 && stat_now[3:2] == 2'b00;
    endproperty
    a_resv: assert property (p_resv)
        else $error("reserved status bit set");

    property p_load;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && r.dp_write && r.dp_addr == DPP_OFF_CMD_STAT &&
         ahb_req.hwdata[7:0] == DPP_CMD_LOAD) |=> (r.upd == 64'h0);
    endproperty
    a_load: assert property (p_load)
        else $error("buffer flags not cleared");

    property p_inc;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && r.dp_write && r.dp_addr == DPP_OFF_WDATA && !r.data_access_protect)
        |=> r.addr_low[5:0] == $past(r.addr_low[5:0]) + 6'd1;
    endproperty
    a_inc: assert property (p_inc)
        else $error("low address not incremented");

    property p_only_flagged;
        @(posedge ref_clk) disable iff (!rst_b)
        array_port.wr_en |-> r.upd[array_port.wr_addr[5:0]];
    endproperty
    a_only_flagged: assert property (p_only_flagged)
        else $error("unflagged byte written");

    property p_secv;
        @(posedge ref_clk) disable iff (!rst_b)
        (clk_en && r.dp_write && r.dp_addr == DPP_OFF_CMD_STAT &&
         (ahb_req.hwdata[7:0] == DPP_CMD_ERASE_PRG ||
          ahb_req.hwdata[7:0] == DPP_CMD_PROGRAM_ONLY_CMD_ONLY) && !r.data_access_protect &&
         r.security[DPP_SEC_CODE]) |=> r.secv && !cpu_stall;
    endproperty
    a_secv: assert property (p_secv)
        else $error("violation not flagged");

    property p_dap;
        @(posedge ref_clk) disable iff (!rst_b)
        r.data_access_protect |-> !array_port.wr_en && !array_port.erase;
    endproperty
    a_dap: assert property (p_dap)
        else $error("array written while protected");

    c_program_only_cmd: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(cpu_stall));
    c_secv: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(r.secv));
    c_wr: cover property (@(posedge ref_clk) disable iff (!rst_b)
        array_port.wr_en);
endmodule

// >>> dpp_pkg.sv
// Package for the data EEPROM page programmer: register map, command
// codes, field positions, timing counts and the carrier structs.
// Assumes a 32-bit AHB-Lite register bus on a 10 MHz clock.
package dpp_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] DPP_OFF_CMD_STAT  = 8'hF4;
    localparam logic [7:0] DPP_OFF_ADDR_LOW  = 8'hE0;
    localparam logic [7:0] DPP_OFF_ADDR_HIGH = 8'hE4;
    localparam logic [7:0] DPP_OFF_WDATA     = 8'hE8;
    localparam logic [7:0] DPP_OFF_SECURITY  = 8'hEC;
    localparam logic [7:0] DPP_OFF_MODE      = 8'hF0;
    localparam logic [7:0] DPP_CMD_STAT_RST  = 8'h00;
    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] DPP_CMD_LOAD      = 8'h00;
    localparam logic [7:0] DPP_CMD_ERASE_PRG = 8'h68;
    localparam logic [7:0] DPP_CMD_PROGRAM_ONLY_CMD_ONLY = 8'h48;
    localparam logic [7:0] DPP_CMD_GLOB_ERS  = 8'h80;
    localparam logic [7:0] DPP_CMD_PAGE_ERS  = 8'h81;
    localparam logic [7:0] DPP_CMD_PAGE_CRC  = 8'h82;
    localparam logic [7:0] DPP_CMD_PROTECT   = 8'h83;
    localparam logic [7:0] DPP_CMD_UNPROTECT = 8'h84;
    // ------------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------------
    localparam int DPP_BIT_FAULT = 0;
    localparam int DPP_BIT_SECV  = 1;
    localparam int DPP_BIT_DAP   = 4;
    localparam int DPP_BIT_WE    = 6;
    localparam int DPP_BIT_BUSY  = 7;
    // Security field positions in the security register
    localparam int DPP_SEC_CODE  = 0;
    localparam int DPP_SEC_PAGE  = 8;
    localparam int DPP_SEC_CRC   = 20;
    // Mode register bits
    localparam int DPP_MODE_ICP  = 0;
    localparam int DPP_MODE_WE   = 1;
    localparam int DPP_MODE_HVE  = 2;
    // ------------------------------------------------------------------
    // Timing: array cycle time
    // ------------------------------------------------------------------
    localparam int DPP_CLK_HZ      = 10_000_000;
    localparam int DPP_PROGRAM_ONLY_CMD_US     = 20;
    localparam int DPP_PROGRAM_ONLY_CMD_CYCLES =
        (DPP_PROGRAM_ONLY_CMD_US * (DPP_CLK_HZ / 1_000_000));
    localparam int DPP_PAGE_BYTES  = 64;
    localparam int DPP_PAGES       = 4;
    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DPP_IDLE = 3'b001,
        DPP_RUN  = 3'b010,
        DPP_DONE = 3'b100
    } dpp_state_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
        logic [31:0] hwdata;
    } dpp_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
    } dpp_ahb_rsp_t;

    typedef struct packed {
        logic        wr_en;
        logic [7:0]  wr_addr;
        logic [7:0]  wr_data;
        logic        erase;
        logic [1:0]  erase_page;
    } dpp_array_t;
endpackage

// >>> tb_top.sv
// Self-checking bench for the data EEPROM page programmer.
// Assumes dpp_pkg and dpp_programmer are compiled first; the bench is the
// only AHB-Lite master and watches the array port directly.
`timescale 1ns/1ps

module tb_top;
    import dpp_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic         ref_clk;
    logic         rst_b;
    logic         abort_strap;
    logic         hv_pin;
    logic         hreadyout;
    logic         hresp;
    logic         stall;
    logic         hold;
    logic [31:0]  hrdata;
    logic [31:0]  rd_val;
    logic [15:0]  wr_log [0:7];
    logic [1:0]   ers_page;
    dpp_ahb_req_t req;
    dpp_ahb_req_t req_bus;
    dpp_array_t   arr;
    int           err_count;
    int           check_count;
    int           wr_cnt;
    int           ers_cnt;

    // The one slave's ready is the bus ready
    always_comb begin
        req_bus = req;
        req_bus.hready = hreadyout;
    end

    // Short program time keeps the run brief; must stay above 64
    dpp_programmer #(.PROGRAM_ONLY_CMD_CYCLES(70)) DUT (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .clk_en        (1'b1),
        .ahb_req       (req_bus),
        .ahb_hreadyout (hreadyout),
        .ahb_hresp     (hresp),
        .ahb_hrdata    (hrdata),
        .hv_error_pin  (hv_pin),
        .abort_strap   (abort_strap),
        .cpu_stall     (stall),
        .irq_hold      (hold),
        .array_port    (arr)
    );

    // ------------------------------------------------------------------
    // Clock, watchdog and array monitor
    // ------------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // A hung wait state would otherwise stall the run forever
    initial begin
        #3_000_000;
        err_count++;
        end_of_test();
    end

    // Log every byte write and erase pulse seen on the array port
    always @(posedge ref_clk) begin
        if (arr.wr_en === 1'b1) begin
            wr_log[wr_cnt[2:0]] <= {arr.wr_addr, arr.wr_data};
            wr_cnt <= wr_cnt + 1;
        end
        if (arr.erase === 1'b1) begin
            ers_cnt <= ers_cnt + 1;
            ers_page <= arr.erase_page;
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One single word transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge ref_clk);
        req.hsel <= 1'b1;
        req.haddr <= {24'h000000, a};
        req.htrans <= 2'b10;
        req.hwrite <= wr;
        req.hsize <= 3'b010;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        req.htrans <= 2'b00;
        req.hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd_val = hrdata;
    endtask

    // Check-only command against one security word, then status read
    task automatic sec_cmd(input string name, input logic [31:0] sec,
                           input logic [7:0] cmd, input logic [31:0] exp);
        xfer(1'b1, DPP_OFF_SECURITY, sec);
        xfer(1'b1, DPP_OFF_CMD_STAT, {24'h0, cmd});
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk(name, rd_val, exp);
    endtask

    task automatic clr_log();
        #1;
        wr_cnt = 0;
        ers_cnt = 0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("status reset", rd_val, 32'h00);
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped read", rd_val, 32'h00);
        chk("okay response", hresp, 1'b0);
        xfer(1'b1, DPP_OFF_MODE, 32'h2);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("write enable", rd_val, 32'h40);
        $display("test reset_and_enable done");
    endtask

    // Two contiguous bytes by auto-increment, then program-only
    task automatic t_program();
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_LOAD);
        xfer(1'b1, DPP_OFF_ADDR_LOW, 32'h7C);
        xfer(1'b1, DPP_OFF_WDATA, 32'hA5);
        xfer(1'b1, DPP_OFF_WDATA, 32'h5A);
        xfer(1'b0, DPP_OFF_ADDR_LOW, 32'h0);
        chk("addr increment", rd_val, 32'h7E);
        clr_log();
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_PROGRAM_ONLY_CMD_ONLY);
        @(posedge ref_clk);
        #1;
        chk("stall high", stall, 1'b1);
        chk("irq hold", hold, 1'b1);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("status after", rd_val, 32'h40);
        chk("stall low", stall, 1'b0);
        chk("write count", wr_cnt, 2);
        chk("first byte", wr_log[0], 16'h7CA5);
        chk("second byte", wr_log[1], 16'h7D5A);
        chk("no erase", ers_cnt, 0);
        $display("test program_only done");
    endtask

    // Buffer clear must drop the earlier flags; one byte on page 3
    task automatic t_erase_program();
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_LOAD);
        xfer(1'b1, DPP_OFF_ADDR_LOW, 32'hC3);
        xfer(1'b1, DPP_OFF_WDATA, 32'h3C);
        clr_log();
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_ERASE_PRG);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("status after", rd_val, 32'h40);
        chk("write count", wr_cnt, 1);
        chk("written byte", wr_log[0], 16'hC33C);
        chk("erase count", ers_cnt, 1);
        chk("erase page", ers_page, 2'h3);
        $display("test erase_program done");
    endtask

    // Refused write under protect, then reset abort and array error;
    // a program start clears the fault before each new source
    task automatic t_fault_protect();
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_PROTECT);
        xfer(1'b1, DPP_OFF_WDATA, 32'h77);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("protected", rd_val, 32'h11);
        xfer(1'b0, DPP_OFF_ADDR_LOW, 32'h0);
        chk("no store", rd_val, 32'hC4);
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_UNPROTECT);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("unprotected", rd_val, 32'h41);
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_PROGRAM_ONLY_CMD_ONLY);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("fault cleared", rd_val, 32'h40);
        @(posedge ref_clk);
        abort_strap <= 1'b1;
        @(posedge ref_clk);
        abort_strap <= 1'b0;
        // Strap passes two flops before the fault is set
        repeat (2) @(posedge ref_clk);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("abort fault", rd_val, 32'h41);
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_PROGRAM_ONLY_CMD_ONLY);
        hv_pin <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hv_pin <= 1'b0;
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("array error", rd_val, 32'h41);
        $display("test fault_protect done");
    endtask

    // Code security set: program is refused with a violation
    task automatic t_security();
        xfer(1'b1, DPP_OFF_SECURITY, 32'h1);
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_LOAD);
        xfer(1'b1, DPP_OFF_ADDR_LOW, 32'h00);
        xfer(1'b1, DPP_OFF_WDATA, 32'h11);
        clr_log();
        xfer(1'b1, DPP_OFF_CMD_STAT, DPP_CMD_PROGRAM_ONLY_CMD_ONLY);
        @(posedge ref_clk);
        #1;
        chk("no stall", stall, 1'b0);
        xfer(1'b0, DPP_OFF_CMD_STAT, 32'h0);
        chk("violation", rd_val, 32'h43);
        chk("no writes", wr_cnt, 0);
        // Each check-only command rewrites the violation flag
        sec_cmd("glob clear", 32'h0, DPP_CMD_GLOB_ERS, 32'h41);
        sec_cmd("glob set", 32'h100, DPP_CMD_GLOB_ERS, 32'h43);
        sec_cmd("erase clear", 32'h100, DPP_CMD_PAGE_ERS, 32'h41);
        sec_cmd("erase set", 32'h400, DPP_CMD_PAGE_ERS, 32'h43);
        sec_cmd("crc clear", 32'h100200, DPP_CMD_PAGE_CRC, 32'h41);
        sec_cmd("crc set", 32'h100000, DPP_CMD_PAGE_CRC, 32'h43);
        $display("test security done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        abort_strap = 1'b0;
        hv_pin = 1'b0;
        req = '0;
        err_count = 0;
        check_count = 0;
        wr_cnt = 0;
        ers_cnt = 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_reset();
        t_program();
        t_erase_program();
        t_fault_protect();
        t_security();
        end_of_test();
    end
endmodule
